// ### verilog/ana_ctrl_pkg.sv
// constants for the power switch and buck converter control registers
// How it works
// - bit 8 of the switch register drives the cpu domain switch, 1 on
// - bit 7 of the switch register drives the radio phy domain switch, 1 on
// - bit 6 of the switch register drives the link layer domain switch, 1 on
// - bit 5 of the switch register drives the flash supply switch, 1 on
// - bit 4 of the switch register drives the low power regulator switch, 1 on
// - bit 3 of the switch register drives the second sram bank switch, 1 on
// - bit 2 of the switch register drives the first sram bank switch, 1 on
// - core field 11/10 enables, 01 disables with pulldown, 00 disables floating
// - buck voltage limit field enables the output voltage limit when 1
// - buck calibration result is read only, shows the converter output, ignores writes
// - auto calibration code 00 off, 01 unused, 10 zero cmp, 11 max current cmp
// - buck test field puts the converter in test mode when 1
// - zero detection trim field is applied to the zero crossing detector
// - overcurrent trim field is applied to the overcurrent detector
`default_nettype none
package ana_ctrl_pkg;

   localparam int unsigned DATA_W = 32;

   // register offsets
   localparam logic [7:0] SWITCH_CTRL_OFFSET = 8'h34;
   localparam logic [7:0] BUCK_CTRL_OFFSET   = 8'h38;

   // power switch register
   localparam logic [31:0] SWITCH_CTRL_RESET = 32'h0000_01ff;
   localparam logic [31:0] SWITCH_CTRL_MASK  = 32'h0000_01ff;
   localparam int unsigned CPU_BIT           = 8;
   localparam int unsigned PHY_BIT           = 7;
   localparam int unsigned LINK_BIT          = 6;
   localparam int unsigned FLASH_BIT         = 5;
   localparam int unsigned LPREG_BIT         = 4;
   localparam int unsigned SRAM1_BIT         = 3;
   localparam int unsigned SRAM0_BIT         = 2;
   localparam int unsigned CORE_LSB          = 0;
   localparam int unsigned CORE_W            = 2;

   // core supply codes
   localparam logic [1:0] CORE_OFF_FLOAT = 2'h0;
   localparam logic [1:0] CORE_OFF_PULL  = 2'h1;

   // buck register layout
   localparam int unsigned BK_EN_BIT     = 0;
   localparam int unsigned BK_VOUT_LSB   = 1;
   localparam int unsigned BK_VOUT_W     = 4;
   localparam int unsigned BK_IMAX_LSB   = 5;
   localparam int unsigned BK_IMAX_W     = 3;
   localparam int unsigned BK_MODE_BIT   = 8;
   localparam int unsigned BK_TEST_BIT   = 9;
   localparam int unsigned BK_OCTRIM_LSB = 12;
   localparam int unsigned BK_ZDTRIM_LSB = 16;
   localparam int unsigned BK_TRIM_W     = 4;
   localparam int unsigned BK_CAL_LSB    = 20;
   localparam int unsigned BK_CAL_W      = 2;
   localparam int unsigned BK_RESULT_BIT = 22;
   localparam int unsigned BK_VLMT_BIT   = 23;
   localparam logic [31:0] BUCK_CTRL_RESET = 32'h0004_2123;
   // writable bits only; result bit and reserved bits excluded
   localparam logic [31:0] BUCK_CTRL_MASK  = 32'h00bf_f3ff;

   // automatic calibration codes
   typedef enum logic [1:0] {
      CAL_OFF     = 2'h0,
      CAL_UNUSED  = 2'h1,
      CAL_ZERO    = 2'h2,
      CAL_MAXCURR = 2'h3
   } cal_code_t;

endpackage
`default_nettype wire

// ### verilog/supply_decode_if.sv
// signals between the register bank and the supply decoder
`timescale 1ns/100ps
`default_nettype none
interface supply_decode_if;
   import ana_ctrl_pkg::*;
   logic [CORE_W-1:0] core_code;
   logic [BK_CAL_W-1:0] cal_code;
   logic core_on;
   logic core_pulldown;
   logic cal_zero_start;
   logic cal_maxcurr_start;

   modport regs (output core_code, output cal_code,
                 input core_on, input core_pulldown, input cal_zero_start, input cal_maxcurr_start);
   modport dec (input core_code, input cal_code,
                output core_on, output core_pulldown, output cal_zero_start, output cal_maxcurr_start);
endinterface
`default_nettype wire

// ### verilog/supply_decode.sv
// decoder for the core supply code and the buck calibration code
`timescale 1ns/100ps
`default_nettype none
module supply_decode
   import ana_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic    clk,
   input  wire logic    rst,
   // codes in, decoded controls out
   supply_decode_if.dec dif
);

   logic core_on_reg,  core_on_next;
   logic core_pd_reg,  core_pd_next;
   logic cal_zero_reg, cal_zero_next;
   logic cal_max_reg,  cal_max_next;

   always_comb begin
      core_on_next = 1'b0;
      core_pd_next = 1'b0;
      unique case (dif.core_code)
         CORE_OFF_FLOAT: core_on_next = 1'b0;
         CORE_OFF_PULL:  core_pd_next = 1'b1;
         default:        core_on_next = 1'b1;
      endcase
      cal_zero_next = 1'b0;
      cal_max_next  = 1'b0;
      unique case (cal_code_t'(dif.cal_code))
         CAL_ZERO:    cal_zero_next = 1'b1;
         CAL_MAXCURR: cal_max_next  = 1'b1;
         CAL_OFF, CAL_UNUSED: cal_zero_next = 1'b0;
      endcase
   end

   // reset matches the register reset codes (core on, calibration off)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_on_reg  <= 1'b1;
         core_pd_reg  <= 1'b0;
         cal_zero_reg <= 1'b0;
         cal_max_reg  <= 1'b0;
      end else begin
         core_on_reg  <= core_on_next;
         core_pd_reg  <= core_pd_next;
         cal_zero_reg <= cal_zero_next;
         cal_max_reg  <= cal_max_next;
      end
   end

   assign dif.core_on           = core_on_reg;
   assign dif.core_pulldown     = core_pd_reg;
   assign dif.cal_zero_start    = cal_zero_reg;
   assign dif.cal_maxcurr_start = cal_max_reg;

endmodule
`default_nettype wire

// ### verilog/power_switch_buck_ctrl_regs.sv
// register bank for power domain switches and buck converter control
`timescale 1ns/100ps
`default_nettype none
module power_switch_buck_ctrl_regs
   import ana_ctrl_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)
(
   // clock and reset
   input  wire logic              CLOCK,
   input  wire logic              RESET,
   // register port
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [31:0]       WDATA,
   input  wire logic              WRITE,
   input  wire logic              READ,
   output logic [31:0]            RDATA,
   // power domain switches
   output logic                   CPU_SWITCH_ON,
   output logic                   PHY_SWITCH_ON,
   output logic                   LINK_SWITCH_ON,
   output logic                   FLASH_SUPPLY_SWITCH_ON,
   output logic                   LPREG_SWITCH_ON,
   output logic                   SRAM_BANK1_SWITCH_ON,
   output logic                   SRAM_BANK0_SWITCH_ON,
   output logic                   CORE_SUPPLY_ON,
   output logic                   CORE_SUPPLY_PULLDOWN,
   // buck converter controls
   output logic                   BUCK_ENABLE,
   output logic [BK_VOUT_W-1:0]   BUCK_VOUT_TRIM,
   output logic [BK_IMAX_W-1:0]   BUCK_CURRENT_LIMIT,
   output logic                   BUCK_SWITCHING_MODE,
   output logic                   BUCK_TEST_ON,
   output logic [BK_TRIM_W-1:0]   BUCK_OVERCURRENT_TRIM,
   output logic [BK_TRIM_W-1:0]   BUCK_ZERO_DETECT_TRIM,
   output logic [BK_CAL_W-1:0]    BUCK_AUTO_CAL_SELECT,
   output logic                   BUCK_CAL_ZERO_START,
   output logic                   BUCK_CAL_MAXCURR_START,
   output logic                   BUCK_VLIMIT_ON,
   // analog calibration result, asynchronous to CLOCK
   input  wire logic              BUCK_CAL_RESULT
);

   initial begin
      if (ADDR_W < 8 || ADDR_W > 32) begin
         $error("ADDR_W must be 8 to 32");
      end
   end

   logic [31:0] sw_reg,    sw_next;
   logic [31:0] buck_reg,  buck_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        cal_meta_reg;
   logic        cal_sync_reg;
   logic        hit_sw;
   logic        hit_buck;

   supply_decode_if dif ();

   assign hit_sw   = (ADDR == ADDR_W'(SWITCH_CTRL_OFFSET));
   assign hit_buck = (ADDR == ADDR_W'(BUCK_CTRL_OFFSET));

   // register writes and read data
   always_comb begin
      sw_next    = sw_reg;
      buck_next  = buck_reg;
      rdata_next = 32'h0000_0000;
      if (WRITE && hit_sw) begin
         sw_next = WDATA & SWITCH_CTRL_MASK;
      end
      // result bit is never taken from a write
      if (WRITE && hit_buck) begin
         buck_next = WDATA & BUCK_CTRL_MASK;
      end
      if (READ) begin
         if (hit_sw) begin
            rdata_next = sw_reg;
         end else if (hit_buck) begin
            rdata_next = buck_reg;
            rdata_next[BK_RESULT_BIT] = cal_sync_reg;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         sw_reg    <= SWITCH_CTRL_RESET;
         buck_reg  <= BUCK_CTRL_RESET & BUCK_CTRL_MASK;
         rdata_reg <= 32'h0000_0000;
      end else begin
         sw_reg    <= sw_next;
         buck_reg  <= buck_next;
         rdata_reg <= rdata_next;
      end
   end

   // the result comes from the analog side, so two flops before use
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         cal_meta_reg <= 1'b0;
         cal_sync_reg <= 1'b0;
      end else begin
         cal_meta_reg <= BUCK_CAL_RESULT;
         cal_sync_reg <= cal_meta_reg;
      end
   end

   assign RDATA = rdata_reg;

   assign CPU_SWITCH_ON          = sw_reg[CPU_BIT];
   assign PHY_SWITCH_ON          = sw_reg[PHY_BIT];
   assign LINK_SWITCH_ON         = sw_reg[LINK_BIT];
   assign FLASH_SUPPLY_SWITCH_ON = sw_reg[FLASH_BIT];
   assign LPREG_SWITCH_ON        = sw_reg[LPREG_BIT];
   assign SRAM_BANK1_SWITCH_ON   = sw_reg[SRAM1_BIT];
   assign SRAM_BANK0_SWITCH_ON   = sw_reg[SRAM0_BIT];

   assign dif.core_code = sw_reg[CORE_LSB +: CORE_W];
   assign dif.cal_code  = buck_reg[BK_CAL_LSB +: BK_CAL_W];

   supply_decode u_decode (
      .clk (CLOCK),
      .rst (RESET),
      .dif (dif.dec)
   );

   assign CORE_SUPPLY_ON         = dif.core_on;
   assign CORE_SUPPLY_PULLDOWN   = dif.core_pulldown;
   assign BUCK_CAL_ZERO_START    = dif.cal_zero_start;
   assign BUCK_CAL_MAXCURR_START = dif.cal_maxcurr_start;

   // buck fields drive their outputs straight from the register, with no high voltage sync
   assign BUCK_ENABLE            = buck_reg[BK_EN_BIT];
   assign BUCK_VOUT_TRIM         = buck_reg[BK_VOUT_LSB +: BK_VOUT_W];
   assign BUCK_CURRENT_LIMIT     = buck_reg[BK_IMAX_LSB +: BK_IMAX_W];
   assign BUCK_SWITCHING_MODE    = buck_reg[BK_MODE_BIT];
   assign BUCK_TEST_ON           = buck_reg[BK_TEST_BIT];
   assign BUCK_OVERCURRENT_TRIM  = buck_reg[BK_OCTRIM_LSB +: BK_TRIM_W];
   assign BUCK_ZERO_DETECT_TRIM  = buck_reg[BK_ZDTRIM_LSB +: BK_TRIM_W];
   assign BUCK_AUTO_CAL_SELECT   = buck_reg[BK_CAL_LSB +: BK_CAL_W];
   assign BUCK_VLIMIT_ON         = buck_reg[BK_VLMT_BIT];

endmodule
`default_nettype wire

// ### dv/ana_ctrl_props.sv
// concurrent checks on the ports of the switch and buck register bank
`timescale 1ns/100ps
`default_nettype none
module ana_ctrl_props
   import ana_ctrl_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)
(
   // clock, reset and register port
   input wire logic              CLOCK,
   input wire logic              RESET,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [31:0]       WDATA,
   input wire logic              WRITE,
   input wire logic              READ,
   input wire logic [31:0]       RDATA,
   // switch outputs
   input wire logic              CPU_SWITCH_ON,
   input wire logic              PHY_SWITCH_ON,
   input wire logic              LINK_SWITCH_ON,
   input wire logic              FLASH_SUPPLY_SWITCH_ON,
   input wire logic              LPREG_SWITCH_ON,
   input wire logic              SRAM_BANK1_SWITCH_ON,
   input wire logic              SRAM_BANK0_SWITCH_ON,
   input wire logic              CORE_SUPPLY_ON,
   input wire logic              CORE_SUPPLY_PULLDOWN,
   // buck outputs
   input wire logic              BUCK_TEST_ON,
   input wire logic              BUCK_VLIMIT_ON,
   input wire logic [1:0]        BUCK_AUTO_CAL_SELECT,
   input wire logic              BUCK_CAL_ZERO_START,
   input wire logic              BUCK_CAL_MAXCURR_START,
   input wire logic              BUCK_CAL_RESULT
);
   logic sw_wr;
   logic bk_wr;
   assign sw_wr = WRITE && (ADDR == ADDR_W'(SWITCH_CTRL_OFFSET));
   assign bk_wr = WRITE && (ADDR == ADDR_W'(BUCK_CTRL_OFFSET));
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   switch_bits_a: assert property (sw_wr |=> {CPU_SWITCH_ON, PHY_SWITCH_ON, LINK_SWITCH_ON,
      FLASH_SUPPLY_SWITCH_ON, LPREG_SWITCH_ON, SRAM_BANK1_SWITCH_ON, SRAM_BANK0_SWITCH_ON} == $past(WDATA[8:2]))
      else $error("switch outputs differ from written bits");
   switch_hold_a: assert property (!sw_wr |=> $stable(CPU_SWITCH_ON))
      else $error("cpu switch moved without a write");
   core_on_a: assert property (sw_wr |-> ##2 CORE_SUPPLY_ON == $past(WDATA[1], 2))
      else $error("core supply enable wrong");
   core_pull_a: assert property (sw_wr |-> ##2 CORE_SUPPLY_PULLDOWN == ($past(WDATA[1:0], 2) == 2'h1))
      else $error("core pulldown wrong");
   cal_start_a: assert property (bk_wr |-> ##2 {BUCK_CAL_ZERO_START, BUCK_CAL_MAXCURR_START} ==
      {$past(WDATA[21:20], 2) == 2'h2, $past(WDATA[21:20], 2) == 2'h3}) else $error("calibration start wrong");
   buck_bits_a: assert property (bk_wr |=> {BUCK_VLIMIT_ON, BUCK_TEST_ON, BUCK_AUTO_CAL_SELECT} ==
      {$past(WDATA[23]), $past(WDATA[9]), $past(WDATA[21:20])}) else $error("buck control outputs wrong");
   rdata_idle_a: assert property (!READ |=> RDATA == 32'h0)
      else $error("read data not zero outside a read");
   sw_reserved_a: assert property (READ && !sw_wr && ADDR == ADDR_W'(8'h34) |=> RDATA[31:9] == 23'h0)
      else $error("reserved switch bits read nonzero");
   cal_result_a: assert property ($stable(BUCK_CAL_RESULT) [*4] ##0 (READ && ADDR == ADDR_W'(8'h38))
      |=> RDATA[22] == $past(BUCK_CAL_RESULT)) else $error("calibration result bit wrong");
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the switch and buck register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   import ana_ctrl_pkg::*;
   logic        clock = 1'b0;
   logic        reset, write, read, core_on, core_pd, bk_en, mode, test, zs, ms, vlim, cal_res;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, d, w;
   logic [6:0]  sw;
   logic [3:0]  vout, oc, zd;
   logic [2:0]  imax;
   logic [1:0]  acal, c;
   int          err_total = 0;
   int          check_count = 0;
   always #12.5 clock = ~clock;
   power_switch_buck_ctrl_regs #(.ADDR_W(8)) u_dut (.CLOCK(clock), .RESET(reset), .ADDR(addr),
      .WDATA(wdata), .WRITE(write), .READ(read), .RDATA(rdata), .CPU_SWITCH_ON(sw[6]), .PHY_SWITCH_ON(sw[5]),
      .LINK_SWITCH_ON(sw[4]), .FLASH_SUPPLY_SWITCH_ON(sw[3]), .LPREG_SWITCH_ON(sw[2]),
      .SRAM_BANK1_SWITCH_ON(sw[1]), .SRAM_BANK0_SWITCH_ON(sw[0]), .CORE_SUPPLY_ON(core_on),
      .CORE_SUPPLY_PULLDOWN(core_pd), .BUCK_ENABLE(bk_en), .BUCK_VOUT_TRIM(vout), .BUCK_CURRENT_LIMIT(imax),
      .BUCK_SWITCHING_MODE(mode), .BUCK_TEST_ON(test), .BUCK_OVERCURRENT_TRIM(oc), .BUCK_ZERO_DETECT_TRIM(zd),
      .BUCK_AUTO_CAL_SELECT(acal), .BUCK_CAL_ZERO_START(zs), .BUCK_CAL_MAXCURR_START(ms),
      .BUCK_VLIMIT_ON(vlim), .BUCK_CAL_RESULT(cal_res));
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      write <= 1'b1;
      @(posedge clock);
      write <= 1'b0;
   endtask
   // read data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      addr <= a;
      read <= 1'b1;
      @(posedge clock);
      read <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      {write, read, addr, wdata, cal_res} = '0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      rd(8'h34, 32'h1ff);
      rd(8'h38, 32'h42123);
      `CHK({sw, core_on, core_pd}, 9'h1fe)
      $display("reset values test done");
      // one switch at a time, core code walking through all four values
      for (int i = 0; i < 7; i++) begin
         d = (32'h4 << i) | 32'(i % 4);
         wr(8'h34, d | 32'hffff_fe00);
         rd(8'h34, d);
         `CHK(sw, d[8:2])
         `CHK({core_on, core_pd}, {d[1], d[1:0] == 2'h1})
      end
      $display("switch test done");
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         w = {8'hff, c[0], 1'b1, c, 4'h5 ^ {c, c}, 4'ha ^ {c, c}, 2'h3, c[1], c[0], {4{c}}};
         // the block has no sync port, so the bench cannot raise one
         wr(8'h38, w);
         rd(8'h38, w & BUCK_CTRL_MASK);
         `CHK({vlim, test, mode}, {w[23], w[9], w[8]})
         `CHK({zd, oc, acal}, {w[19:16], w[15:12], c})
         `CHK({zs, ms}, {c == 2'h2, c == 2'h3})
         `CHK({vout, imax, bk_en}, {w[4:1], w[7:5], w[0]})
      end
      $display("buck test done");
      @(posedge clock);
      cal_res <= 1'b1;
      repeat (4) @(posedge clock);
      wr(8'h38, w & 32'hffbf_ffff);
      rd(8'h38, (w & BUCK_CTRL_MASK) | 32'h0040_0000);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0);
      rd(8'h34, d);
      `CHK(sw, d[8:2])
      $display("calibration and unmapped test done");
      test_done();
   end
   initial begin
      repeat (5000) @(posedge clock);
      err_total++;
      test_done();
   end
endmodule
bind power_switch_buck_ctrl_regs ana_ctrl_props #(.ADDR_W(ADDR_W)) u_props (.CLOCK(CLOCK), .RESET(RESET),
   .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .CPU_SWITCH_ON(CPU_SWITCH_ON),
   .PHY_SWITCH_ON(PHY_SWITCH_ON), .LINK_SWITCH_ON(LINK_SWITCH_ON), .FLASH_SUPPLY_SWITCH_ON(FLASH_SUPPLY_SWITCH_ON),
   .LPREG_SWITCH_ON(LPREG_SWITCH_ON), .SRAM_BANK1_SWITCH_ON(SRAM_BANK1_SWITCH_ON),
   .SRAM_BANK0_SWITCH_ON(SRAM_BANK0_SWITCH_ON), .CORE_SUPPLY_ON(CORE_SUPPLY_ON),
   .CORE_SUPPLY_PULLDOWN(CORE_SUPPLY_PULLDOWN), .BUCK_TEST_ON(BUCK_TEST_ON), .BUCK_VLIMIT_ON(BUCK_VLIMIT_ON),
   .BUCK_AUTO_CAL_SELECT(BUCK_AUTO_CAL_SELECT), .BUCK_CAL_ZERO_START(BUCK_CAL_ZERO_START),
   .BUCK_CAL_MAXCURR_START(BUCK_CAL_MAXCURR_START), .BUCK_CAL_RESULT(BUCK_CAL_RESULT));
`default_nettype wire
